// ### cs_unit_defines.svh
// constants and register map of the chip-select and wait-state unit
// ****************************************************************
// Contract
// - upper select covers a block ending at FFFFFh; only its low bound is programmable.
// - two low ready-mode bits give upper-region wait state count.
// - lower select covers a block from address zero; upper bound programmable.
// - up to seven peripheral selects; indices 0 to 4 select on-board peripherals.
// - relocation register: escape trap 15, slave 14, mem/io 12, A19-A8 in 11-0.
// ****************************************************************
`ifndef CS_UNIT_DEFINES_SVH
`define CS_UNIT_DEFINES_SVH
`define ADDR_UPPER 3'h0
`define ADDR_LOWER 3'h1
`define ADDR_MID 3'h2
`define ADDR_MIDPER 3'h3
`define ADDR_PBASE 3'h4
`define ADDR_RELOC 3'h5
`define ADDR_STATUS 3'h6
`define RST_UPPER 16'hFFFB
`define RST_LOWER 16'h0000
`define RST_MID 16'h0000
`define RST_MIDPER 16'h0000
`define RST_PBASE 16'h0000
`define RST_RELOC 16'h40FF
`define RDY_INT_BIT 2
`define EXPAND_BIT 7
`define SPACE_BIT 6
`define ET_BIT 15
`define SLAVE_BIT 14
`define RELOC_MIO_BIT 12
`define ADDR_TOP 20'hFFFFF
`define PSEL_EXT_READY 4
`define PSEL_BLOCK_SHIFT 7
`define BOUND_HI 15
`define BOUND_LO 6
`define BLOCK_LO 10
`define PAGE_LO 8
`define RELOC_HI 11
`define WAIT_HI 1
`endif

// ### cs_unit_pkg.sv
// types shared by the chip-select and wait-state unit
package cs_unit_pkg;
    typedef logic [15:0] reg16_t;
    typedef logic [19:0] addr_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_DONE = 3'b100
    } wait_state_t;
endpackage : cs_unit_pkg

// ### wait_gen.sv
// wait-state generator for one bus cycle
`include "cs_unit_defines.svh"
module wait_gen (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // cycle control
    input wire logic cycle_start,
    input wire logic [1:0] wait_count,
    input wire logic use_ext_ready,
    input wire logic ext_ready,
    // result
    output logic ready_out,
    output logic busy
);
    import cs_unit_pkg::*;
    wait_state_t state_reg, state_next;
    logic [1:0] cnt_reg, cnt_next;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            ST_IDLE: begin
                if (cycle_start) begin
                    cnt_next = wait_count;
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // count down first, then optionally hold for external ready
                if (cnt_reg != 2'h0) begin
                    cnt_next = cnt_reg - 2'h1;
                end else if (!use_ext_ready || ext_ready) begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 2'h0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    assign ready_out = (state_reg == ST_DONE);
    assign busy = (state_reg != ST_IDLE);
endmodule : wait_gen

// ### cs_unit.sv
// chip-select, ready-mode and control-block relocation unit
`include "cs_unit_defines.svh"
module cs_unit #(
    parameter int NUM_PSEL = 7
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register port
    input wire logic [2:0] reg_addr,
    input wire cs_unit_pkg::reg16_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output cs_unit_pkg::reg16_t reg_rdata,
    // processor bus cycle
    input wire cs_unit_pkg::addr_t cyc_addr,
    input wire logic cyc_start,
    input wire logic cyc_io,
    input wire logic ext_ready_pin,
    // selects and ready
    output logic upper_region_select_n,
    output logic lower_region_select_n,
    output logic [4:0] periph_select_n,
    output logic latched_a1,
    output logic latched_a2,
    output logic ctrl_block_hit,
    output logic cyc_ready
);
    import cs_unit_pkg::*;

    // ****************************************************************
    // registers
    // ****************************************************************
    reg16_t upper_reg, upper_next;
    reg16_t lower_reg, lower_next;
    reg16_t mid_reg, mid_next;
    reg16_t midper_reg, midper_next;
    reg16_t pbase_reg, pbase_next;
    reg16_t reloc_reg, reloc_next;
    reg16_t rdata_reg, rdata_next;

    always_comb begin
        upper_next = upper_reg;
        lower_next = lower_reg;
        mid_next = mid_reg;
        midper_next = midper_reg;
        pbase_next = pbase_reg;
        reloc_next = reloc_reg;
        if (reg_wr) begin
            case (reg_addr)
                `ADDR_UPPER: upper_next = reg_wdata;
                `ADDR_LOWER: lower_next = reg_wdata;
                // kept only so software can read it back; selects never use it
                `ADDR_MID: mid_next = reg_wdata;
                `ADDR_MIDPER: midper_next = reg_wdata;
                `ADDR_PBASE: pbase_next = reg_wdata;
                `ADDR_RELOC: reloc_next = reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // ****************************************************************
    // decode
    // ****************************************************************
    logic upper_hit, lower_hit, reloc_hit;
    logic [NUM_PSEL-1:0] psel_hit;
    logic [9:0] upper_base;
    logic [9:0] lower_limit;
    logic [19:0] pblock_base;
    logic [2:0] psel_idx;
    logic sync1_reg, sync2_reg;
    logic wg_busy;

    // block size follows directly from the whole bound field, compared against address bits 19 to 10
    assign upper_base = upper_reg[`BOUND_HI:`BOUND_LO];
    assign lower_limit = lower_reg[`BOUND_HI:`BOUND_LO];
    // the top end is fixed, so the programmed low bound is compared along with the constant ADDR_TOP
    assign upper_hit = !cyc_io && (cyc_addr[19:`BLOCK_LO] >= upper_base)
        && (cyc_addr <= `ADDR_TOP);
    assign lower_hit = !cyc_io && (cyc_addr[19:`BLOCK_LO] <= lower_limit);
    assign pblock_base = {pbase_reg[`BOUND_HI:`BOUND_LO], 10'h000};
    assign psel_idx = cyc_addr[`PSEL_BLOCK_SHIFT +: 3];
    assign reloc_hit = (cyc_io != reloc_reg[`RELOC_MIO_BIT])
        && (cyc_addr[19:`PAGE_LO] == reloc_reg[`RELOC_HI:0]);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PSEL; gi++) begin : g_psel
            // select space follows the mem/io space bit
            assign psel_hit[gi] = (cyc_io == !midper_reg[`SPACE_BIT])
                && (cyc_addr[19:`BLOCK_LO] == pblock_base[19:`BLOCK_LO])
                && (psel_idx == 3'(gi));
        end
    endgenerate

    // ****************************************************************
    // wait states and ready
    // ****************************************************************
    logic [1:0] wsel_count;
    logic wsel_ext;
    always_comb begin
        wsel_count = 2'h0;
        wsel_ext = 1'b0;
        if (psel_hit[`PSEL_EXT_READY]) begin
            // this select waits for the pin as well, whatever its ready-mode bit says
            wsel_count = midper_reg[`WAIT_HI:0];
            wsel_ext = 1'b1;
        end else if ((|psel_hit[NUM_PSEL-1:`PSEL_EXT_READY+1])
                && midper_reg[`EXPAND_BIT]) begin
            // the two top selects take their wait states from midper_reg only while the expand bit is set
            wsel_count = midper_reg[`WAIT_HI:0];
            wsel_ext = !midper_reg[`RDY_INT_BIT];
        end else if (|psel_hit) begin
            wsel_count = pbase_reg[`WAIT_HI:0];
            wsel_ext = !pbase_reg[`RDY_INT_BIT];
        end else if (upper_hit) begin
            wsel_count = upper_reg[`WAIT_HI:0];
            wsel_ext = !upper_reg[`RDY_INT_BIT];
        end else if (lower_hit) begin
            wsel_count = lower_reg[`WAIT_HI:0];
            wsel_ext = !lower_reg[`RDY_INT_BIT];
        end
    end

    wait_gen u_wait (
        .clk(clk),
        .resetn(resetn),
        .cycle_start(cyc_start),
        .wait_count(wsel_count),
        .use_ext_ready(wsel_ext),
        .ext_ready(sync2_reg),
        .ready_out(cyc_ready),
        .busy(wg_busy)
    );

    // ****************************************************************
    // outputs and read path
    // ****************************************************************
    logic up_sel_next, lo_sel_next, a1_next, a2_next, crb_next;
    logic [4:0] ps_next;
    logic up_sel_reg, lo_sel_reg, a1_reg, a2_reg, crb_reg;
    logic [4:0] ps_reg;
    always_comb begin
        up_sel_next = !upper_hit;
        lo_sel_next = !lower_hit;
        ps_next = ~psel_hit[4:0];
        crb_next = reloc_hit;
        // latched_a1 and latched_a2 take address bits 1 and 2 at every cycle start, whatever the expand bit
        a1_next = cyc_start ? cyc_addr[1] : a1_reg;
        a2_next = cyc_start ? cyc_addr[2] : a2_reg;
        // read data stand one cycle after the strobe and read zero otherwise
        rdata_next = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                `ADDR_UPPER: rdata_next = upper_reg;
                `ADDR_LOWER: rdata_next = lower_reg;
                `ADDR_MID: rdata_next = mid_reg;
                `ADDR_MIDPER: rdata_next = midper_reg;
                `ADDR_PBASE: rdata_next = pbase_reg;
                `ADDR_RELOC: rdata_next = reloc_reg;
                `ADDR_STATUS: rdata_next = {7'h00, wg_busy, 1'b0, ~ps_reg, up_sel_reg, lo_sel_reg};
                default: rdata_next = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            upper_reg <= `RST_UPPER;
            lower_reg <= `RST_LOWER;
            mid_reg <= `RST_MID;
            midper_reg <= `RST_MIDPER;
            pbase_reg <= `RST_PBASE;
            reloc_reg <= `RST_RELOC;
            rdata_reg <= 16'h0000;
            up_sel_reg <= 1'b1;
            lo_sel_reg <= 1'b1;
            ps_reg <= 5'h1F;
            a1_reg <= 1'b0;
            a2_reg <= 1'b0;
            crb_reg <= 1'b0;
        end else begin
            upper_reg <= upper_next;
            lower_reg <= lower_next;
            mid_reg <= mid_next;
            midper_reg <= midper_next;
            pbase_reg <= pbase_next;
            reloc_reg <= reloc_next;
            rdata_reg <= rdata_next;
            up_sel_reg <= up_sel_next;
            lo_sel_reg <= lo_sel_next;
            ps_reg <= ps_next;
            a1_reg <= a1_next;
            a2_reg <= a2_next;
            crb_reg <= crb_next;
        end
    end

    // ****************************************************************
    // ready pin synchroniser
    // ****************************************************************
    // the pin is asynchronous: only the second flop feeds the wait generator
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= ext_ready_pin;
            sync2_reg <= sync1_reg;
        end
    end

    assign reg_rdata = rdata_reg;
    assign upper_region_select_n = up_sel_reg;
    assign lower_region_select_n = lo_sel_reg;
    assign periph_select_n = ps_reg;
    assign latched_a1 = a1_reg;
    assign latched_a2 = a2_reg;
    assign ctrl_block_hit = crb_reg;
endmodule : cs_unit

// ### cs_periph_model.sv
// far-side model: peripheral on select 4 that answers ready after a stall
module cs_periph_model (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // stall length and select
    input wire logic [3:0] stall,
    input wire logic periph4_select_n,
    // ready answer
    output logic ext_ready_pin
);
    logic [3:0] cnt_reg, cnt_next;
    always_comb begin
        cnt_next = periph4_select_n ? 4'h0 : cnt_reg + {3'h0, cnt_reg != 4'hF};
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= 4'h0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
    // an unselected device leaves the line at not-ready, never a stale high
    assign ext_ready_pin = !periph4_select_n && cnt_reg >= stall;
endmodule : cs_periph_model

// ### cs_unit_props.sv
// assertion checker for the chip-select unit
module cs_unit_props (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [2:0] reg_addr,
    input wire cs_unit_pkg::reg16_t reg_wdata,
    input wire logic reg_wr,
    input wire cs_unit_pkg::addr_t cyc_addr,
    input wire logic cyc_start,
    input wire logic cyc_io,
    input wire logic upper_region_select_n,
    input wire logic lower_region_select_n,
    input wire logic [4:0] periph_select_n,
    input wire logic latched_a1,
    input wire logic latched_a2,
    input wire logic cyc_ready
);
    import cs_unit_pkg::*;
    // shadow bounds so decode is judged against what software wrote
    reg16_t up_reg, up_next, lo_reg, lo_next;
    always_comb begin
        up_next = (reg_wr && reg_addr == 3'h0) ? reg_wdata : up_reg;
        lo_next = (reg_wr && reg_addr == 3'h1) ? reg_wdata : lo_reg;
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            up_reg <= 16'hFFFB;
            lo_reg <= 16'h0000;
        end else begin
            up_reg <= up_next;
            lo_reg <= lo_next;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    upper_top_a: assert property (
        $past(resetn) && $past(cyc_addr) == 20'hFFFFF && !$past(cyc_io) |-> !upper_region_select_n)
        else $error("upper select off at top address");
    lower_zero_a: assert property (
        $past(resetn) && $past(cyc_addr) == 20'h00000 && !$past(cyc_io) |-> !lower_region_select_n)
        else $error("lower select off at address zero");
    upper_decode_a: assert property (
        $past(resetn) && !$past(cyc_io) |->
        upper_region_select_n == ($past(cyc_addr[19:10]) < $past(up_reg[15:6])))
        else $error("upper select disagrees with bound");
    lower_decode_a: assert property (
        $past(resetn) && !$past(cyc_io) |->
        lower_region_select_n == ($past(cyc_addr[19:10]) > $past(lo_reg[15:6])))
        else $error("lower select disagrees with bound");
    ready_pulse_a: assert property (cyc_ready |=> !cyc_ready)
        else $error("ready longer than one cycle");
    ready_bound_a: assert property (cyc_start |-> ##[2:60] cyc_ready)
        else $error("ready early or missing");
    latch_addr_a: assert property (
        cyc_start |=> latched_a1 == $past(cyc_addr[1]) && latched_a2 == $past(cyc_addr[2]))
        else $error("latched address bits wrong");
    psel_onehot_a: assert property ($onehot0(~periph_select_n))
        else $error("several peripheral selects active");
endmodule : cs_unit_props
bind cs_unit cs_unit_props props (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .cyc_addr(cyc_addr), .cyc_start(cyc_start),
    .cyc_io(cyc_io), .upper_region_select_n(upper_region_select_n),
    .lower_region_select_n(lower_region_select_n), .periph_select_n(periph_select_n),
    .latched_a1(latched_a1), .latched_a2(latched_a2), .cyc_ready(cyc_ready));

// ### tb_cs_unit.sv
// self-checking testbench of the chip-select unit
`include "cs_unit_defines.svh"
module tb_cs_unit import cs_unit_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, cyc_start = 1'b0;
    logic cyc_io = 1'b0, ext_ready_pin, upsel_n, losel_n, a1, a2, hit, cyc_ready;
    logic [2:0] reg_addr = 3'h0;
    logic [4:0] psel_n;
    logic [3:0] stall = 4'hF;
    reg16_t reg_wdata = 16'h0000, reg_rdata, rv;
    addr_t cyc_addr = 20'h00000;
    int n_mismatch = 0, cmp_count = 0, n;
    always #50 clk = ~clk;
    cs_unit DUT (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cyc_addr(cyc_addr),
        .cyc_start(cyc_start), .cyc_io(cyc_io), .ext_ready_pin(ext_ready_pin),
        .upper_region_select_n(upsel_n), .lower_region_select_n(losel_n),
        .periph_select_n(psel_n), .latched_a1(a1), .latched_a2(a2),
        .ctrl_block_hit(hit), .cyc_ready(cyc_ready));
    cs_periph_model partner (.clk(clk), .resetn(resetn), .stall(stall),
        .periph4_select_n(psel_n[4]), .ext_ready_pin(ext_ready_pin));
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic wr(input logic [2:0] a, input reg16_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask : rd
    // counts edges after the one that raises the start until ready shows
    task automatic cycle(input addr_t a, input logic io);
        @(posedge clk);
        cyc_addr <= a;
        cyc_io <= io;
        cyc_start <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            cyc_start <= 1'b0;
            n++;
            #1;
        end while (cyc_ready !== 1'b1 && n < 40);
    endtask : cycle
    task automatic t_regs;
        // status at address zero: only the lower select is active
        reg16_t rst [8] = '{`RST_UPPER, `RST_LOWER, `RST_MID, `RST_MIDPER, `RST_PBASE,
            `RST_RELOC, 16'h0002, 16'h0000};
        reg16_t cfg [8] = '{16'hFE3D, 16'h3FFC, 16'h0000, 16'h003F, 16'h00BF, 16'h5040,
            16'h0002, 16'h0000};
        for (int i = 0; i < 8; i++) begin
            rd(3'(i));
            check("reset value", rst[i], rv);
        end
        // the mid register is never written, the unmapped index takes a write
        for (int i = 0; i < 8; i++) if (i != 2 && i != 6) wr(3'(i), 16'hFFFF);
        for (int i = 0; i < 6; i++) if (i != 2) wr(3'(i), cfg[i]);
        for (int i = 0; i < 8; i++) begin
            rd(3'(i));
            check("config readback", cfg[i], rv);
        end
        $display("test registers done");
    endtask : t_regs
    task automatic t_decode;
        addr_t da [9] = '{20'hFFFFF, 20'hFE000, 20'hFDFFF, 20'h00000, 20'h3FFFF, 20'h40000,
            20'h04000, 20'h040FF, 20'h04100};
        logic [7:0] de [9] = '{8'h7E, 8'h7E, 8'hFE, 8'hBE, 8'hBE, 8'hFE, 8'hBF, 8'hBF, 8'hBE};
        logic [5:0] pe;
        for (int i = 0; i < 9; i++) begin
            @(posedge clk);
            cyc_addr <= da[i];
            cyc_io <= 1'b0;
            @(posedge clk);
            #1 check("region decode", de[i], {upsel_n, losel_n, psel_n, hit});
        end
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            cyc_addr <= 20'h00780 + 20'(i * 128);
            cyc_io <= 1'b1;
            @(posedge clk);
            // step i lands on select i-1; steps 0 and 6 leave all five lines idle
            pe = ~(6'h01 << i);
            #1 check("periph select", pe[5:1], psel_n);
        end
        $display("test decode done");
    endtask : t_decode
    task automatic t_wait;
        for (int k = 0; k < 4; k++) begin
            wr(3'h0, 16'hFE3C | 16'(k));
            cycle(20'hFFFF6, 1'b0);
            check("upper waits", k + 2, n);
        end
        check("latched bits", 2'b11, {a2, a1});
        cycle(20'h00000, 1'b0);
        check("lower waits", 2, n);
        cycle(20'h00800, 1'b1);
        check("periph0 waits", 5, n);
        wr(3'h3, 16'h003F);
        stall <= 4'h8;
        cycle(20'h00A00, 1'b1);
        check("periph4 ext ready", 1, n >= 10 && n <= 16);
        $display("test wait states done");
    endtask : t_wait
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        t_regs();
        t_decode();
        t_wait();
        summarize();
    end
    // whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        summarize();
    end
endmodule : tb_cs_unit
